//--- src/tic_ctrl.sv
/*
 * timer interrupt controller: control register at data address 0bh,
 * request latching, arbitration, vectoring, return handling and wake.
 * assumes a cpu sequencer that presents data-memory accesses for one
 * cycle, pulses the phase-two strobe once per machine cycle, performs the
 * pc push / branch on o_ack, and reports each call push and each pop; the ack push is counted here.
 * limitation: the stack counter trusts those reports; a push while full
 * saturates silently instead of flagging an overflow.
 */
`include "tic_cfg.svh"

module tic_ctrl #(
    parameter int STACK_DEPTH = `TIC_STACK_DEPTH
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // data memory access to the control register
    input wire logic [7:0] i_mem_addr,
    input wire logic i_mem_wr,
    input wire logic [7:0] i_mem_wdata,
    output logic [7:0] o_mem_rdata,
    // timer overflow pulses
    input wire logic i_t0_ovf,
    input wire logic i_t1_ovf,
    // cpu sequencer
    input wire logic i_phase_two,
    input wire logic i_call_push,
    input wire logic i_ret_pop,
    input wire logic i_ret_isr,
    input wire logic i_halted,
    output logic o_ack,
    output logic [15:0] o_vector,
    output logic o_push_pc,
    output logic o_wake,
    output logic [$clog2(STACK_DEPTH+1)-1:0] o_stack_level
);

    // =================================================================
    // helpers
    // reset image taken apart per field, so one constant governs all
    // five fields and a new reset value cannot leave one behind
    localparam logic [7:0] CTRL_RESET = `TIC_CTRL_RESET;

    // one decode serves the write strobe and the read-back mux, so the
    // two can never disagree about where the register sits
    function automatic logic is_ctrl_addr(input logic [7:0] addr);
        return addr == `TIC_CTRL_ADDR;
    endfunction : is_ctrl_addr

    // branch target of a winning source; none keeps a harmless zero
    function automatic logic [15:0] src_vector(
        input tic_pkg::tic_src_t src
    );
        logic [15:0] vec;
        vec = 16'h0000;
        unique case (src)
            tic_pkg::TIC_SRC_T0: vec = `TIC_VEC_T0;
            tic_pkg::TIC_SRC_T1: vec = `TIC_VEC_T1;
            default: vec = 16'h0000;
        endcase
        return vec;
    endfunction : src_vector

    // register image as software sees it; the used-bit mask keeps the
    // spare positions at zero even if a field is ever moved
    function automatic logic [7:0] ctrl_image(
        input logic g,
        input logic e0,
        input logic e1,
        input logic r0,
        input logic r1
    );
        logic [7:0] img;
        img = 8'h00;
        img[`TIC_BIT_GIE] = g;
        img[`TIC_BIT_T0_EN] = e0;
        img[`TIC_BIT_T1_EN] = e1;
        img[`TIC_BIT_T0_REQ] = r0;
        img[`TIC_BIT_T1_REQ] = r1;
        return img & `TIC_CTRL_USED_MASK;
    endfunction : ctrl_image

    // =================================================================
    // stack occupancy
    logic stack_full;
    logic ack_q;
    // an acknowledge counts as a push one cycle late; the global enable
    // is already clear by then, so no second service can slip in while
    // the level is catching up

    tic_stack_level #(
        .DEPTH(STACK_DEPTH)
    ) u_stack (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_push(i_call_push | ack_q),
        .i_pop(i_ret_pop | i_ret_isr),
        .o_level(o_stack_level),
        .o_full(stack_full)
    );

    // =================================================================
    // control register fields
    logic gie;
    logic t0_en;
    logic t1_en;
    logic t0_req;
    logic t1_req;
    logic ctrl_wr;
    tic_pkg::tic_src_t next_src;

    assign ctrl_wr = i_mem_wr && is_ctrl_addr(i_mem_addr);

    // both enables needed; full stack holds off
    // fixed priority, timer 0 first
    // a blocked request never reaches next_src; its flag waits
    always_comb begin
        next_src = tic_pkg::TIC_SRC_NONE;
        if (gie && !stack_full) begin
            if (t0_req && t0_en) begin
                next_src = tic_pkg::TIC_SRC_T0;
            end else if (t1_req && t1_en) begin
                next_src = tic_pkg::TIC_SRC_T1;
            end
        end
    end

    // service is only taken on a phase-two strobe
    logic take;
    assign take = i_phase_two && (next_src != tic_pkg::TIC_SRC_NONE);
    // the strobe gates only the decision; flags keep latching between
    // strobes and the winner is picked from what stands at the strobe

    // enables: software writes them; service entry clears global
    // enable, return_from_isr sets it, plain return leaves it alone
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            gie <= CTRL_RESET[`TIC_BIT_GIE];
            t0_en <= CTRL_RESET[`TIC_BIT_T0_EN];
            t1_en <= CTRL_RESET[`TIC_BIT_T1_EN];
        end else begin
            if (ctrl_wr) begin
                gie <= i_mem_wdata[`TIC_BIT_GIE];
                t0_en <= i_mem_wdata[`TIC_BIT_T0_EN];
                t1_en <= i_mem_wdata[`TIC_BIT_T1_EN];
            end
            if (i_ret_isr) begin
                gie <= 1'b1;
            end
            // entry wins over any same-cycle write so nesting stays off
            if (take) begin
                gie <= 1'b0;
            end
        end
    end

    // request flags: a software clear loses to a same-cycle overflow;
    // the overflow set comes last so it also beats a service clear
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            t0_req <= CTRL_RESET[`TIC_BIT_T0_REQ];
            t1_req <= CTRL_RESET[`TIC_BIT_T1_REQ];
        end else begin
            if (ctrl_wr) begin
                t0_req <= i_mem_wdata[`TIC_BIT_T0_REQ];
                t1_req <= i_mem_wdata[`TIC_BIT_T1_REQ];
            end
            if (take && next_src == tic_pkg::TIC_SRC_T0) begin
                t0_req <= 1'b0;
            end
            if (take && next_src == tic_pkg::TIC_SRC_T1) begin
                t1_req <= 1'b0;
            end
            // latched even while blocked
            if (i_t0_ovf) begin
                t0_req <= 1'b1;
            end
            if (i_t1_ovf) begin
                t1_req <= 1'b1;
            end
        end
    end

    // =================================================================
    // acknowledge and vector
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            ack_q <= 1'b0;
            o_vector <= 16'h0000;
        end else begin
            ack_q <= take;
            // held after the pulse so the sequencer may fetch it late
            if (take) begin
                o_vector <= src_vector(next_src);
            end
        end
    end

    assign o_ack = ack_q;
    // only the pc is pushed; status is the program's job
    assign o_push_pc = ack_q;

    // a flag already set before halt gives no wake, so a request that
    // software left pending does not wake it again on a repeat
    // wake on a new overflow while halted, whatever the enables
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_wake <= 1'b0;
        end else begin
            o_wake <= i_halted && ((i_t0_ovf && !t0_req) ||
                (i_t1_ovf && !t1_req));
        end
    end

    // =================================================================
    // read-back; unused bits 1,4,7 read zero
    always_comb begin
        o_mem_rdata = 8'h00;
        if (is_ctrl_addr(i_mem_addr)) begin
            o_mem_rdata = ctrl_image(gie, t0_en, t1_en, t0_req, t1_req);
        end
    end

endmodule : tic_ctrl

//--- src/tic_cfg.svh
/*
 * constants of the timer interrupt controller: register offset, bit
 * positions, reset value, vectors and stack depth.
 * assumes it is included once per compilation unit by its bare name.
 */
// Function
// - clear global enable when service begins
// - blocked requests still latch and stay pending
// - full stack withholds acknowledge, request stays pending
// - each timer request can wake from halt
// - acknowledge pushes only program counter, then vectors
// - timer 0 overflow sets flag bit 5
// - timer 0 service: call 08h, clear flag, enable
// - timer 1 same; enable bit 3, flag bit 6
// - return_from_isr sets enable; plain return does not
// - requests acknowledged at next phase-two edge
// - timer 0 wins over timer 1; vectors 08h/0ch
// - control register lives at data address 0bh
// - flags hold until serviced or software clears
// - service needs global and individual enable
// - global enable bit 0; bits 1,4,7 read zero
// - timer 0 enable at bit 2
`ifndef TIC_CFG_SVH
`define TIC_CFG_SVH

// =====================================================================
// register map
`define TIC_CTRL_ADDR 8'h0b
`define TIC_CTRL_RESET 8'h00
`define TIC_BIT_GIE 0
`define TIC_BIT_T0_EN 2
`define TIC_BIT_T1_EN 3
`define TIC_BIT_T0_REQ 5
`define TIC_BIT_T1_REQ 6
`define TIC_CTRL_USED_MASK 8'h6d

// =====================================================================
// vectors and stack
`define TIC_VEC_T0 16'h0008
`define TIC_VEC_T1 16'h000c
`define TIC_STACK_DEPTH 8

`endif

//--- src/tic_pkg.sv
/*
 * types of the timer interrupt controller.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package tic_pkg;

    typedef enum logic [1:0] {
        TIC_SRC_NONE,
        TIC_SRC_T0,
        TIC_SRC_T1
    } tic_src_t;

endpackage : tic_pkg

//--- src/tic_stack_level.sv
/*
 * call-stack occupancy counter for the interrupt controller.
 * assumes the cpu never pushes when full nor pops when empty.
 */
`include "tic_cfg.svh"

module tic_stack_level #(
    parameter int DEPTH = `TIC_STACK_DEPTH
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_push,
    input wire logic i_pop,
    output logic [$clog2(DEPTH+1)-1:0] o_level,
    output logic o_full
);

    localparam int LW = $clog2(DEPTH + 1);

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_level <= '0;
        end else if (i_push && !i_pop && o_level != LW'(DEPTH)) begin
            o_level <= o_level + LW'(1);
        end else if (i_pop && !i_push && o_level != '0) begin
            o_level <= o_level - LW'(1);
        end
    end

    assign o_full = (o_level == LW'(DEPTH));

endmodule : tic_stack_level

//--- tb/tic_ctrl_props.sv
/* checker of tic_ctrl port behaviour, bound into every tic_ctrl.
   assumes one clock and the synchronous active-high reset. */
// ==================================================================
// properties
module tic_ctrl_props #(parameter int STACK_DEPTH = 8) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_phase_two,
    input wire logic o_ack,
    input wire logic o_push_pc,
    input wire logic [7:0] i_mem_addr,
    input wire logic [7:0] o_mem_rdata,
    input wire logic [15:0] o_vector,
    input wire logic [$clog2(STACK_DEPTH+1)-1:0] o_stack_level,
    input wire logic i_ret_pop,
    input wire logic i_ret_isr,
    input wire logic i_halted,
    input wire logic i_t0_ovf,
    input wire logic o_wake
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);
    sequence s_t0_armed;
        i_phase_two && i_mem_addr == 8'h0b && (o_mem_rdata & 8'h25) ==
        8'h25 && o_stack_level < STACK_DEPTH;
    endsequence
    a_t0_serviced: assert property (
        s_t0_armed |=> o_ack && o_vector == 16'h0008) else $error("t0");
    a_ack_on_phase: assert property (
        o_ack |-> $past(i_phase_two)) else $error("phase");
    a_push_only_pc: assert property (
        o_push_pc == o_ack) else $error("push");
    a_unused_zero: assert property (
        (o_mem_rdata & 8'h92) == 8'h00) else $error("unused");
    a_ack_clears_gie: assert property (
        o_ack && i_mem_addr == 8'h0b |-> !o_mem_rdata[0]) else $error("gie");
    a_ack_single: assert property (
        o_ack |=> !o_ack) else $error("nested");
    a_full_no_ack: assert property (
        o_stack_level == STACK_DEPTH |=> !o_ack) else $error("full");
    a_gie_gates: assert property (
        i_mem_addr == 8'h0b && !o_mem_rdata[0] |=> !o_ack) else $error("off");
    a_push_level: assert property (
        o_push_pc && !i_ret_pop && !i_ret_isr |=>
        o_stack_level == $past(o_stack_level) + 1) else $error("level");
    a_wake_t0: assert property (
        i_halted && i_t0_ovf && i_mem_addr == 8'h0b && !o_mem_rdata[5]
        |=> o_wake) else $error("wake");
endmodule : tic_ctrl_props

bind tic_ctrl tic_ctrl_props #(.STACK_DEPTH(STACK_DEPTH)) i_props (.*);

//--- tb/tic_cpu_model.sv
/* cpu sequencer model: phase-two strobe once per four-clock machine
   cycle; assumes the bench clock and synchronous active-high reset. */
// ==================================================================
// sequencer
module tic_cpu_model (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    output logic o_phase_two
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] q;
    always_ff @(posedge i_clk) q <= i_sys_rst ? 2'h0 : q + 2'h1;
    assign o_phase_two = q == 2'h2;
endmodule : tic_cpu_model

//--- tb/tb_tic_ctrl.sv
/* bench of the timer interrupt controller: data port, timer and
   sequencer strobes; assumes design, checker and cpu model compiled. */
// ==================================================================
// bench
module tb_tic_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, halted = 1'b0;
    logic [7:0] addr = 8'h0b, wd = 8'h00, rd;
    logic [4:0] p = 5'h00;
    logic ph, ack, wake;
    logic [15:0] vec;
    logic [3:0] lvl;
    int mismatches = 0, tests_run = 0;
    always #2 clk = ~clk;
    tic_cpu_model i_cpu (.i_clk(clk), .i_sys_rst(rst), .o_phase_two(ph));
    tic_ctrl i_dut (.i_clk(clk), .i_sys_rst(rst), .i_mem_addr(addr),
        .i_mem_wr(wr), .i_mem_wdata(wd), .o_mem_rdata(rd),
        .i_t0_ovf(p[0]), .i_t1_ovf(p[1]), .i_phase_two(ph),
        .i_call_push(p[2]), .i_ret_pop(p[3]), .i_ret_isr(p[4]),
        .i_halted(halted), .o_ack(ack), .o_vector(vec), .o_push_pc(),
        .o_wake(wake), .o_stack_level(lvl));
    task chk(input logic [15:0] s, e);
        tests_run++;
        if (s !== e) begin
            mismatches++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task drv(input logic [4:0] v, input logic w, input logic [7:0] d);
        @(negedge clk);
        {addr, p, wr, wd} = {8'h0b, v, w, d};
        @(negedge clk);
        {p, wr} = 6'h00;
    endtask : drv
    // twelve cycles span three machine cycles, so a due ack is seen
    task ack_is(input logic e, input logic [15:0] v);
        @(negedge clk);
        for (int n = 0; n < 12 && ack !== 1'b1; n++) @(negedge clk);
        chk(16'(ack), 16'(e));
        if (e) chk(vec, v);
    endtask : ack_is
    task results;
        $display("compares %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : results
    initial begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        chk(16'(rd), 16'h0000);
        drv(5'h00, 1'b1, 8'h9e);
        chk(16'(rd), 16'h000c);
        addr = 8'h0a;
        #1 chk(16'(rd), 16'h0000);
        drv(5'h01, 1'b1, 8'h00);
        chk(16'(rd), 16'h0020);
        ack_is(1'b0, 16'h0000);
        drv(5'h02, 1'b0, 8'h00);
        chk(16'(rd), 16'h0060);
        $display("test flags done");
        drv(5'h00, 1'b1, 8'h6d);
        ack_is(1'b1, 16'h0008);
        chk(16'(rd), 16'h004c);
        ack_is(1'b0, 16'h0000);
        drv(5'h10, 1'b0, 8'h00);
        ack_is(1'b1, 16'h000c);
        drv(5'h08, 1'b0, 8'h00);
        chk(16'(rd), 16'h000c);
        chk(16'(lvl), 16'h0000);
        $display("test service done");
        repeat (8) drv(5'h04, 1'b0, 8'h00);
        chk(16'(lvl), 16'h0008);
        drv(5'h00, 1'b1, 8'h25);
        ack_is(1'b0, 16'h0000);
        drv(5'h08, 1'b0, 8'h00);
        ack_is(1'b1, 16'h0008);
        halted = 1'b1;
        drv(5'h02, 1'b0, 8'h00);
        chk(16'(wake), 16'h0001);
        drv(5'h02, 1'b0, 8'h00);
        chk(16'(wake), 16'h0000);
        drv(5'h01, 1'b0, 8'h00);
        chk(16'(wake), 16'h0001);
        $display("test stack and wake done");
        results;
    end
    initial begin
        #40000;
        mismatches++;
        results;
    end
endmodule : tb_tic_ctrl
